//--- core/ccpwm_unit.sv
// Purpose: Capture, compare and pulse-width unit with APB registers
// Assumes: pclk is the oscillator; conv_done comes from pclk logic
// Notes: One wait state on every APB access
// Functional notes
// RULE_01: Special-event match raises interrupt, starts conversion
// RULE_02: Special-event match clears time base, sets go
// RULE_03: Control pattern 00001011 selects special-event mode
// RULE_04: 16-bit time base, step 4 clocks times prescale
// RULE_05: PWM period is limit plus one steps
// RULE_06: Duty is ten bits, LSBs from control 5:4
// RULE_07: Control holds mode and duty LSBs together
// RULE_08: Capture latches time base on chosen edge
// RULE_09: Compare match raises unit interrupt
// RULE_10: Mode may change live; one function at once
// RULE_11: Unit flag sticky until software clears it
`include "ccpwm_map.svh"
module ccpwm_unit import ccpwm_pkg::*; #(
   parameter int TB_W = 16,
   parameter int PER_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic unit_pin_in,
   output logic unit_pin_out,
   output logic unit_pin_oe,
   output logic conv_start,
   input wire logic conv_done,
   output logic irq
);
   // Logic below is written for these widths only
   if (TB_W != 16 || PER_W != 8) begin : g_chk
      $error("ccpwm_unit supports TB_W=16 and PER_W=8 only");
   end

   ccpwm_ctrl_s ctrl_q;
   logic [15:0] value_q;
   logic [7:0] duty_q;
   logic [7:0] period_q;
   logic [3:0] psc_q;
   logic [15:0] tb1_q;
   logic [7:0] tb2_q;
   logic [1:0] fine_q;
   logic [9:0] duty_lat_q;
   logic [4:0] c_cnt_q;
   logic [3:0] p_cnt_q;
   logic conv_q;
   logic [1:0] sts_q;
   logic [1:0] msk_q;
   logic [1:0] sts_d;
   logic sync1_q, sync2_q, sync3_q;
   ccpwm_pin_s pin_q;
   logic irq_q, pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic acc, wr, tick1, tq, hit, cap_ev, unit_ev, pwm_wrap;
   logic wr_ctrl, wr_tb1, wr_sts;
   logic cmp_mode, cap_mode, spec_mode, pwm_mode;
   logic [9:0] pos_q, pos_d, lat_d;

   // Pclk cycles per capture step, minus one
   function automatic logic [4:0] cap_last(input logic [1:0] sel);
      logic [5:0] n;
      n = 6'(`CCPWM_STEP_CLKS) << sel;
      return 5'(n - 6'h01);
   endfunction

   // Pclk cycles per PWM quarter step, minus one (1, 4, 16)
   function automatic logic [3:0] pwm_last(input logic [1:0] sel);
      logic [3:0] r;
      r = 4'h0;
      unique case (sel)
         2'b00: r = 4'h0;
         2'b01: r = 4'h3;
         2'b10: r = 4'hF;
         2'b11: r = 4'hF;
      endcase
      return r;
   endfunction

   // Register address match used by writes
   function automatic logic is_wr(input logic [7:0] ofs);
      return wr && paddr == ofs;
   endfunction

   // Mode decode follows the control register at once
   assign cap_mode = ctrl_q.mode inside {CCPWM_CAP_FALL, CCPWM_CAP_RISE};
   assign cmp_mode = ctrl_q.mode[3:2] == 2'b10; // RULE_10
   assign spec_mode = ctrl_q.mode == CCPWM_CMP_SPEC;
   assign pwm_mode = ctrl_q.mode[3:2] == 2'b11;

   // APB access phase and committed write
   assign acc = psel && penable;
   assign wr = acc && pwrite && pready_q;

   // Named write strobes, so checks see plain sampled signals
   assign wr_ctrl = is_wr(`CCPWM_OFS_CTRL);
   assign wr_tb1 = is_wr(`CCPWM_OFS_TB1);
   assign wr_sts = is_wr(`CCPWM_OFS_STS);

   // APB answer: one wait state, then pready for a single cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= acc && !pready_q;
         pslverr_q <= 1'b0;
         if (acc && !pready_q) begin
            prdata_q <= 32'h0000_0000;
            unique case (paddr)
               `CCPWM_OFS_CTRL: prdata_q[7:0] <= ctrl_q;
               `CCPWM_OFS_VAL_LO: prdata_q[7:0] <= value_q[7:0];
               `CCPWM_OFS_VAL_HI: prdata_q[7:0] <= value_q[15:8];
               `CCPWM_OFS_DUTY: prdata_q[7:0] <= duty_q;
               `CCPWM_OFS_PERIOD: prdata_q[7:0] <= period_q;
               `CCPWM_OFS_PSC: prdata_q[3:0] <= psc_q;
               `CCPWM_OFS_TB1: prdata_q[15:0] <= tb1_q;
               `CCPWM_OFS_TB2: prdata_q[7:0] <= tb2_q;
               `CCPWM_OFS_CONV: prdata_q[0] <= conv_q;
               `CCPWM_OFS_STS: prdata_q[1:0] <= sts_q;
               `CCPWM_OFS_MSK: prdata_q[1:0] <= msk_q;
               default: pslverr_q <= 1'b1; // Unmapped address
            endcase
         end
      end
   end

   // Software-only configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CCPWM_RST_CTRL;
         duty_q <= `CCPWM_RST_DUTY;
         period_q <= `CCPWM_RST_PERIOD;
         psc_q <= `CCPWM_RST_PSC;
         msk_q <= 2'h0;
      end else begin
         if (is_wr(`CCPWM_OFS_CTRL))
            ctrl_q <= pwdata[7:0]; // RULE_03 RULE_07
         if (is_wr(`CCPWM_OFS_DUTY))
            duty_q <= pwdata[7:0];
         if (is_wr(`CCPWM_OFS_PERIOD))
            period_q <= pwdata[7:0];
         if (is_wr(`CCPWM_OFS_PSC))
            psc_q <= pwdata[3:0];
         if (is_wr(`CCPWM_OFS_MSK))
            msk_q <= pwdata[1:0];
      end
   end

   // Capture prescaler; tick1 marks one time-base step
   assign tick1 = c_cnt_q >= cap_last(psc_q[1:0]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         c_cnt_q <= 5'h00;
      else if (tick1)
         c_cnt_q <= 5'h00;
      else
         c_cnt_q <= c_cnt_q + 5'h01;
   end

   // Compare match is judged once per step, so it fires once
   assign hit = tick1 && cmp_mode && tb1_q == value_q; // RULE_09

   // Capture time base, free running; software write wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tb1_q <= 16'h0000;
      else if (is_wr(`CCPWM_OFS_TB1))
         tb1_q <= pwdata[15:0];
      else if (hit && spec_mode)
         tb1_q <= 16'h0000; // RULE_02
      else if (tick1)
         tb1_q <= tb1_q + 16'h0001; // RULE_04
   end

   // Edge input: two flops, then a third only for edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= unit_pin_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // Edge polarity comes from the mode code
   assign cap_ev = cap_mode && (ctrl_q.mode[0] ? (sync2_q && !sync3_q)
                                : (!sync2_q && sync3_q)); // RULE_08

   // Value register; a capture beats a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         value_q <= `CCPWM_RST_VALUE;
      else if (cap_ev)
         value_q <= tb1_q; // RULE_08
      else if (is_wr(`CCPWM_OFS_VAL_LO))
         value_q[7:0] <= pwdata[7:0];
      else if (is_wr(`CCPWM_OFS_VAL_HI))
         value_q[15:8] <= pwdata[7:0];
   end

   // Conversion go bit: special event beats write beats done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         conv_q <= 1'b0;
      else if (hit && spec_mode)
         conv_q <= 1'b1; // RULE_01 RULE_02
      else if (is_wr(`CCPWM_OFS_CONV))
         conv_q <= pwdata[`CCPWM_CONV_GO];
      else if (conv_done)
         conv_q <= 1'b0;
   end

   // PWM quarter-step prescaler, idle outside PWM mode
   assign tq = p_cnt_q >= pwm_last(psc_q[3:2]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         p_cnt_q <= 4'h0;
      else if (!pwm_mode || tq)
         p_cnt_q <= 4'h0;
      else
         p_cnt_q <= p_cnt_q + 4'h1;
   end

   // Position is time base plus two quarter bits, 4 per step
   assign pos_q = {tb2_q, fine_q};
   assign pwm_wrap = pwm_mode && tq && pos_q == {period_q, 2'b11}; // RULE_05

   // Next position and duty; new duty only starts a period
   always_comb begin
      pos_d = pos_q;
      lat_d = duty_lat_q;
      if (!pwm_mode) begin
         pos_d = 10'h000;
      end else if (pwm_wrap) begin
         pos_d = 10'h000;
         lat_d = {duty_q, ctrl_q.duty_lsb}; // RULE_06 RULE_07
      end else if (tq) begin
         pos_d = pos_q + 10'h001;
      end
   end

   // PWM time base and latched duty
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tb2_q <= 8'h00;
         fine_q <= 2'b00;
         duty_lat_q <= 10'h000;
      end else begin
         tb2_q <= pos_d[9:2]; // RULE_05
         fine_q <= pos_d[1:0];
         duty_lat_q <= lat_d;
      end
   end

   // Pin: PWM level, or compare set/clear on match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= '0;
      end else begin
         pin_q.oe <= pwm_mode || ctrl_q.mode inside
                     {CCPWM_CMP_SET, CCPWM_CMP_CLR};
         if (pwm_mode)
            pin_q.out <= pos_d < lat_d; // RULE_06
         else if (hit && ctrl_q.mode == CCPWM_CMP_SET)
            pin_q.out <= 1'b1;
         else if (hit && ctrl_q.mode == CCPWM_CMP_CLR)
            pin_q.out <= 1'b0;
         else if (!cmp_mode)
            pin_q.out <= 1'b0;
      end
   end

   // Sticky flags: a new event wins over a same-cycle clear
   assign unit_ev = hit || cap_ev; // RULE_01 RULE_09
   always_comb begin
      sts_d = sts_q;
      if (is_wr(`CCPWM_OFS_STS))
         sts_d = sts_q & ~pwdata[1:0];
      sts_d[`CCPWM_STS_UNIT] = sts_d[`CCPWM_STS_UNIT] || unit_ev; // RULE_11
      sts_d[`CCPWM_STS_PWM] = sts_d[`CCPWM_STS_PWM] || pwm_wrap;
   end

   // Level interrupt from registered flags and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         sts_q <= sts_d;
         irq_q <= |(sts_d & (is_wr(`CCPWM_OFS_MSK) ? pwdata[1:0] : msk_q));
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign unit_pin_out = pin_q.out;
   assign unit_pin_oe = pin_q.oe;
   assign conv_start = conv_q;
   assign irq = irq_q;

   // Checks on the unit's own behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_spec_event: assert property (hit && spec_mode |=> // RULE_01
      conv_q && sts_q[`CCPWM_STS_UNIT])
      else $error("special event missed go or flag");
   chk_spec_clear: assert property (hit && spec_mode && // RULE_02
      !wr_tb1 |=> tb1_q == 16'h0000 ##1 tb1_q == 16'h0000)
      else $error("special event did not clear time base");
   chk_mode_code: assert property (wr_ctrl && // RULE_03
      pwdata[7:0] == 8'h0B |=> spec_mode)
      else $error("pattern 00001011 not special event");
   chk_tb1_step: assert property (!wr_tb1 && // RULE_04
      !(hit && spec_mode) |=> tb1_q == $past(tb1_q) + 16'($past(tick1)))
      else $error("time base stepped wrongly");
   chk_pwm_wrap: assert property (pwm_wrap |=> // RULE_05
      tb2_q == 8'h00 && fine_q == 2'b00 && !pwm_wrap)
      else $error("pwm period did not restart");
   chk_duty_load: assert property (pwm_wrap |=> // RULE_06
      duty_lat_q == {$past(duty_q), $past(ctrl_q.duty_lsb)})
      else $error("duty not loaded at period start");
   chk_capture_val: assert property (cap_ev |=> // RULE_08
      value_q == $past(tb1_q) && sts_q[`CCPWM_STS_UNIT])
      else $error("capture did not latch time base");
   chk_cmp_flag: assert property (hit && !spec_mode |=> // RULE_09
      sts_q[`CCPWM_STS_UNIT] && tb1_q == $past(tb1_q) + 16'h0001)
      else $error("compare match lost");
   chk_flag_sticky: assert property (sts_q[`CCPWM_STS_UNIT] && // RULE_11
      !(wr_sts && pwdata[0]) |=> sts_q[`CCPWM_STS_UNIT])
      else $error("unit flag dropped without clear");
   chk_irq_level: assert property (irq_q == |(sts_q & msk_q))
      else $error("interrupt level disagrees with flags");

   cov_spec: cover property (hit && spec_mode ##1 conv_q);
   cov_cap_rise: cover property (cap_ev && ctrl_q.mode[0]);
   cov_pwm_wrap: cover property (pwm_wrap && duty_lat_q != 10'h000);
   cov_clear_race: cover property (unit_ev && wr_sts);
endmodule // ccpwm_unit

//--- core/ccpwm_map.svh
// Purpose: Offsets, field positions, reset values and step clock count of the unit
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef CCPWM_MAP_SVH
`define CCPWM_MAP_SVH
// Register byte offsets
`define CCPWM_OFS_CTRL 8'h00
`define CCPWM_OFS_VAL_LO 8'h04
`define CCPWM_OFS_VAL_HI 8'h08
`define CCPWM_OFS_DUTY 8'h0C
`define CCPWM_OFS_PERIOD 8'h10
`define CCPWM_OFS_PSC 8'h14
`define CCPWM_OFS_TB1 8'h18
`define CCPWM_OFS_TB2 8'h1C
`define CCPWM_OFS_CONV 8'h20
`define CCPWM_OFS_STS 8'h24
`define CCPWM_OFS_MSK 8'h28
// Field positions
`define CCPWM_CONV_GO 0
`define CCPWM_STS_UNIT 0
`define CCPWM_STS_PWM 1
// Reset values
`define CCPWM_RST_CTRL 8'h00
`define CCPWM_RST_VALUE 16'h0000
`define CCPWM_RST_DUTY 8'h00
`define CCPWM_RST_PERIOD 8'hFF
`define CCPWM_RST_PSC 4'h0
// Oscillator periods per time-base step at prescale 1:1
`define CCPWM_STEP_CLKS 4
`endif

//--- core/ccpwm_pkg.sv
// Purpose: Types shared by the capture, compare and pulse-width unit
// Assumes: Nothing beyond the map header
// Notes: Mode codes sit in the low nibble of the control register
package ccpwm_pkg;
   typedef enum logic [3:0] {
      CCPWM_OFF = 4'b0000,
      CCPWM_CAP_FALL = 4'b0100,
      CCPWM_CAP_RISE = 4'b0101,
      CCPWM_CMP_SET = 4'b1000,
      CCPWM_CMP_CLR = 4'b1001,
      CCPWM_CMP_INT = 4'b1010,
      CCPWM_CMP_SPEC = 4'b1011,
      CCPWM_PWM = 4'b1100
   } ccpwm_mode_e;
   // Control register layout
   typedef struct packed {
      logic [1:0] spare;
      logic [1:0] duty_lsb;
      logic [3:0] mode;
   } ccpwm_ctrl_s;
   // Unit pin as two signals
   typedef struct packed {
      logic out;
      logic oe;
   } ccpwm_pin_s;
endpackage

//--- verif/ccpwm_far.sv
// Purpose: Far-side model: external pulse source and converter
// Assumes: Converter watches the go level on pclk
// Notes: Slow converter, so go stays high for several cycles
module ccpwm_far #(
   parameter int DONE_CLKS = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_cmd,
   input wire logic conv_start,
   output logic conv_done,
   output logic unit_pin_in
);
   int cnt;
   // Pulse line follows the bench; it is never left floating
   assign unit_pin_in = pin_cmd;
   // Conversion ends a fixed time after go; done is one pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         if (!conv_start) begin
            cnt <= 0;
         end else if (cnt == DONE_CLKS) begin
            cnt <= 0;
            conv_done <= 1'b1;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule // ccpwm_far

//--- verif/ccpwm_unit_test.sv
// Purpose: Self-checking bench for the capture, compare and PWM unit
// Assumes: APB slave answers in its own time; far side from ccpwm_far
// Notes: Random values from a fixed seed; times counted in pclk cycles
`include "ccpwm_map.svh"
module ccpwm_unit_test import ccpwm_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pin_cmd, serr, conv_d;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, pin_out, pin_oe, conv_go, conv_done, irq, pin_in;
   logic [15:0] v;
   int err_total, n_checks, cyc, n_conv, t0, p, d, c0;
   ccpwm_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .unit_pin_in(pin_in), .unit_pin_out(pin_out), .unit_pin_oe(pin_oe),
      .conv_start(conv_go), .conv_done(conv_done), .irq(irq));
   ccpwm_far far (.pclk(pclk), .presetn(presetn), .pin_cmd(pin_cmd),
      .conv_start(conv_go), .conv_done(conv_done), .unit_pin_in(pin_in));
   // Clock, 50 ns period
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Cycle count and converter start edges
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      conv_d <= conv_go;
      if (conv_go === 1'b1 && conv_d !== 1'b1) n_conv <= n_conv + 1;
   end
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] dat);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      // No limit here; the watchdog ends a hung transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      apb(1'b1, a, dat);
      chk("write error", 0, serr);
   endtask
   task automatic rdr(input logic [7:0] a);
      apb(1'b0, a, 0);
   endtask
   // Bounded wait for the interrupt line
   task automatic wirq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      chk("irq raised", 1, irq);
   endtask
   // Cycles until the pin reaches a level, bounded
   task automatic run_to(input logic lv, output int c);
      c = 0;
      while (pin_out !== lv && c < 999) begin
         @(posedge pclk);
         c++;
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      #(50 * 40000);
      err_total++;
      $display("watchdog expired");
      finish_test();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pin_cmd = 1'b0;
      void'($urandom(32'hc5bd_2a1a));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and an unmapped place
      rdr(`CCPWM_OFS_PERIOD);
      chk("period reset", 32'h0000_00ff, rd);
      rdr(`CCPWM_OFS_CTRL);
      chk("control reset", 0, rd);
      rdr(8'h40);
      chk("unmapped error", 1, serr);
      chk("unmapped data", 0, rd);
      $display("test reset done");
      // Special event: clears base, starts conversion, sticky flag
      v = 16'($urandom_range(40, 8));
      p = $urandom_range(3, 0);
      wr(`CCPWM_OFS_PSC, p);
      wr(`CCPWM_OFS_VAL_LO, v[7:0]);
      wr(`CCPWM_OFS_VAL_HI, v[15:8]);
      wr(`CCPWM_OFS_TB1, 0);
      wr(`CCPWM_OFS_MSK, 1);
      c0 = n_conv;
      wr(`CCPWM_OFS_CTRL, 8'b0000_1011);
      wirq(2000);
      t0 = cyc;
      wr(`CCPWM_OFS_STS, 3);
      rdr(`CCPWM_OFS_TB1);
      chk("base cleared", 1, rd < v);
      wirq(2000);
      chk("event period", (v + 1) * (4 << p), cyc - t0);
      // Start-edge counter updates one edge after go rises
      @(posedge pclk);
      chk("conversions", 2, n_conv - c0);
      repeat ((v + 1) * (4 << p) + 8) @(posedge pclk);
      chk("flag sticky", 1, irq);
      wr(`CCPWM_OFS_CTRL, 0);
      wr(`CCPWM_OFS_STS, 3);
      repeat (2) @(posedge pclk);
      chk("flag cleared", 0, irq);
      $display("test special done");
      // Compare modes: pin set, pin clear, interrupt only; one wraps
      wr(`CCPWM_OFS_PSC, 0);
      for (int i = 0; i < 3; i++) begin
         v = (i == 2) ? 16'h0001 : 16'($urandom_range(60000, 16));
         wr(`CCPWM_OFS_VAL_LO, v[7:0]);
         wr(`CCPWM_OFS_VAL_HI, v[15:8]);
         wr(`CCPWM_OFS_CTRL, CCPWM_CMP_SET + i);
         wr(`CCPWM_OFS_STS, 3);
         wr(`CCPWM_OFS_TB1, v - 16'h0003);
         wirq(60);
         if (i < 2) chk("pin level", i == 0, pin_out);
         chk("pin enable", i < 2, pin_oe);
         rdr(`CCPWM_OFS_TB1);
         chk("base runs on", 1, 16'(rd[15:0] - v) < 8);
      end
      $display("test compare done");
      // Capture on falling edge only, masked; then on rising edge
      wr(`CCPWM_OFS_PSC, 3);
      wr(`CCPWM_OFS_MSK, 0);
      wr(`CCPWM_OFS_CTRL, CCPWM_CAP_FALL);
      v = 16'($urandom());
      wr(`CCPWM_OFS_TB1, v);
      wr(`CCPWM_OFS_STS, 3);
      pin_cmd <= 1'b1;
      repeat (6) @(posedge pclk);
      rdr(`CCPWM_OFS_STS);
      chk("no capture on rise", 0, rd[0]);
      pin_cmd <= 1'b0;
      repeat (6) @(posedge pclk);
      rdr(`CCPWM_OFS_STS);
      chk("capture on fall", 1, rd[0]);
      chk("masked irq", 0, irq);
      rdr(`CCPWM_OFS_VAL_LO);
      d = rd[7:0];
      rdr(`CCPWM_OFS_VAL_HI);
      chk("captured", 1, 16'({rd[7:0], d[7:0]} - v) < 2);
      wr(`CCPWM_OFS_MSK, 1);
      repeat (2) @(posedge pclk);
      chk("unmasked irq", 1, irq);
      wr(`CCPWM_OFS_CTRL, CCPWM_CAP_RISE);
      wr(`CCPWM_OFS_STS, 3);
      repeat (2) @(posedge pclk);
      chk("irq after clear", 0, irq);
      pin_cmd <= 1'b1;
      wirq(20);
      $display("test capture done");
      // PWM at two quarter rates: high time and period
      for (int q = 1; q <= 4; q += 3) begin
         int hi, lo;
         // Stop first so the position restarts below the new limit
         wr(`CCPWM_OFS_CTRL, 0);
         p = $urandom_range(12, 3);
         d = $urandom_range((p + 1) * 4 - 1, 1);
         wr(`CCPWM_OFS_PSC, (q == 4) ? 4 : 0);
         wr(`CCPWM_OFS_PERIOD, p);
         wr(`CCPWM_OFS_DUTY, d >> 2);
         wr(`CCPWM_OFS_CTRL, {d[1:0], CCPWM_PWM});
         repeat ((p + 1) * 12 * q) @(posedge pclk);
         run_to(1'b0, lo);
         run_to(1'b1, lo);
         run_to(1'b0, hi);
         run_to(1'b1, lo);
         chk("high time", d * q, hi);
         chk("pwm period", (p + 1) * 4 * q, hi + lo);
         chk("pwm enable", 1, pin_oe);
      end
      $display("test pwm done");
      finish_test();
   end
endmodule // ccpwm_unit_test
